// file: hdl/eeprom_wp_pkg.sv
// Constants for the serial memory status and write control block.
// Assumes a single 100 MHz clock; all serial pins arrive asynchronously.
//
// Behaviour
// [RULE1] Busy flag reads 1 for the whole internal write cycle, host cannot write it.
// [RULE2] Set-latch command sets the write latch, clear-latch command clears it.
// [RULE3] Two protect-select bits pick none, top quarter, top half or whole array.
// [RULE4] Addresses inside the selected protected range are never programmed.
// [RULE5] Pin low with arm bit set blocks status writes; unprotected array stays writable.
// [RULE6] Latch clear refuses all writes; latch set allows unprotected and status writes.
// [RULE7] Page-select bit steers access to the identification page, clears after use.
// [RULE8] Page-lock bit, once set, makes the identification page read-only forever; here sys_rst clears it.
// [RULE9] Setting page-select and page-lock together leaves both unchanged.
// [RULE10] After reset the write latch is clear.
// [RULE11] Writes need the latch set and a target outside the protected area.
// [RULE12] The latch is set only when the set-latch session ends with select rising.
// [RULE13] Byte write is opcode, 24-bit address, data; only 17 address bits count.
// [RULE14] Programming starts only at the select rise closing a valid write session.
// [RULE15] While busy, every command except read-status is ignored.
// [RULE16] Page write takes up to 256 bytes, low address bits wrap inside the page.
// [RULE17] End of an internal write cycle clears the write latch.
// [RULE18] Identification writes use A7-A0 as start; A16-A15 must be unprotected.
// [RULE19] Whole array protected means identification page writes are ignored.
// [RULE20] First byte after select falls is decoded; only six opcodes are accepted.
// [RULE21] Status write changes bits 2, 3, 4, 6 and 7 only.
// [RULE22] Pin going low during an armed status write session abandons that write.
// [RULE23] Inputs sampled on serial clock rise, outputs shifted on its fall.
// [RULE24] Status writes that change non-volatile bits run a busy cycle, commit at end.
// [RULE25] Internal write cycle length is a parameter counted in clock cycles.

package eeprom_wp_pkg;

    // Clock and self-timed write cycle
    localparam int unsigned CLK_HZ    = 100_000_000;
    localparam int unsigned T_WC_MS   = 5;
    localparam int unsigned WC_CYCLES = CLK_HZ / 1000 * T_WC_MS;

    // Instruction codes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_WRITE     = 8'h02;
    localparam logic [7:0] OP_NONE      = 8'h00;

    // Status register bit positions
    localparam int BIT_BUSY  = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 3;
    localparam int BIT_LOCK  = 4;
    localparam int BIT_IDSEL = 6;
    localparam int BIT_ARM   = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Protect-select encodings
    localparam logic [1:0] BP_NONE    = 2'b00;
    localparam logic [1:0] BP_QUARTER = 2'b01;
    localparam logic [1:0] BP_HALF    = 2'b10;
    localparam logic [1:0] BP_FULL    = 2'b11;

    // Serial framing and address widths
    localparam int          ADDR_W        = 17;
    localparam int          OFS_W         = 8;
    localparam logic [4:0]  LAST_BYTE_BIT = 5'd7;
    localparam logic [4:0]  LAST_ADDR_BIT = 5'd23;
    localparam logic [2:0]  LAST_OUT_BIT  = 3'd7;

    // Load stream word: {id page, address, data}
    localparam int LOAD_W     = 1 + ADDR_W + 8;
    localparam int LOAD_DEPTH = 8;

endpackage

// file: hdl/load_fifo.sv
// Synchronous FIFO carrying page-load words to the array.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none

module load_fifo #(
    parameter int W     = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;

    // Handshake terms
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    // Storage needs no reset; only pointers and fill count carry state
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // load_fifo

`default_nettype wire

// file: hdl/spi_eeprom_write_protect_control.sv
// Serial memory front end: command decode, status register, protection
// and the page-load path toward the array.
// Assumes the array answers rd_data combinationally from rd_addr/rd_id,
// buffers loaded words and programs them on prog_commit.
`timescale 1ns/1ps
`default_nettype none

module spi_eeprom_write_protect_control
    import eeprom_wp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WC_CYCLES,
    parameter int          FIFO_DEPTH   = LOAD_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Serial pins
    input  wire logic              cs_n,
    input  wire logic              sck,
    input  wire logic              si,
    input  wire logic              wp_n,
    output logic                   so,
    output logic                   so_oe,
    // Array read port
    output logic [ADDR_W-1:0]      rd_addr,
    output logic                   rd_id,
    input  wire logic [7:0]        rd_data,
    // Page-load stream
    output logic                   ld_valid,
    input  wire logic              ld_ready,
    output logic [ADDR_W-1:0]      ld_addr,
    output logic                   ld_id,
    output logic [7:0]             ld_data,
    // Programming control
    output logic                   prog_commit,
    output logic                   prog_abort,
    output logic [7:0]             status
);

    typedef enum logic [6:0] {
        S_IDLE  = 7'b0000001,
        S_OPC   = 7'b0000010,
        S_ADDR  = 7'b0000100,
        S_WDATA = 7'b0001000,
        S_SDATA = 7'b0010000,
        S_OUT   = 7'b0100000,
        S_DEAD  = 7'b1000000
    } sess_t;

    // True when a region address falls in the protected range
    function automatic logic prot_hit(input logic [1:0] bp,
                                      input logic [1:0] a16_15);
        // [RULE3] range encoding
        case (bp)
            BP_QUARTER: prot_hit = (a16_15 == 2'b11);
            BP_HALF:    prot_hit = a16_15[1];
            BP_FULL:    prot_hit = 1'b1;
            default:    prot_hit = 1'b0;
        endcase
    endfunction

    // Synchronisers; stage 0 feeds only stage 1
    logic [2:0] sck_r;
    logic [2:0] cs_r;
    logic [1:0] si_r;
    logic [1:0] wp_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_r <= 3'h0;
            cs_r  <= 3'h7;
            si_r  <= 2'h0;
            wp_r  <= 2'h3;
        end else begin
            sck_r <= {sck_r[1:0], sck};
            cs_r  <= {cs_r[1:0], cs_n};
            si_r  <= {si_r[0], si};
            wp_r  <= {wp_r[0], wp_n};
        end
    end

    // [RULE23] sample on rise, shift on fall
    wire sck_rise = sck_r[1] & ~sck_r[2];
    wire sck_fall = ~sck_r[1] & sck_r[2];
    wire cs_lo    = ~cs_r[1];
    wire cs_fall  = ~cs_r[1] & cs_r[2];
    wire cs_rise  = cs_r[1] & ~cs_r[2];
    wire si_b     = si_r[1];
    wire wp_lo    = ~wp_r[1];

    // Session and status state
    sess_t             state_q;
    logic [7:0]        sh_q;
    logic [4:0]        bit_q;
    logic [7:0]        op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [OFS_W-1:0]  ofs_q;
    logic              nb_q;
    logic              ovr_q;
    logic              wp_seen_q;
    logic [7:0]        sdata_q;
    logic              sok_q;
    logic              busy_q;
    logic              pend_q;
    logic              kind_st_q;
    logic [31:0]       cnt_q;
    logic [3:0]        nv_pend_q;
    logic              latch_q;
    logic [1:0]        bp_q;
    logic              lock_q;
    logic              idsel_q;
    logic              arm_q;
    logic [7:0]        out_sh_q;
    logic [2:0]        fcnt_q;
    logic              so_q;
    logic              ld_rd_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic              push_q;
    logic [LOAD_W-1:0] push_w_q;
    logic              commit_q;
    logic              abort_q;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [LOAD_W-1:0] fifo_out_data;

    // Decode of the incoming byte and busy view
    wire [7:0] byte_in   = {sh_q[6:0], si_b};
    wire       busy_any  = busy_q | pend_q;
    wire       last_byte = sck_rise & (bit_q == LAST_BYTE_BIT);
    wire       last_addr = sck_rise & (bit_q == LAST_ADDR_BIT);

    // [RULE1] busy shown while pending or programming
    assign status = {arm_q, idsel_q, 1'b0, lock_q, bp_q, latch_q, busy_any};

    // [RULE5] pin protection only when armed
    wire hw_prot = arm_q & (wp_seen_q | wp_lo);

    // [RULE18] id page region check on A16:A15
    wire reg_hit = prot_hit(bp_q, addr_q[ADDR_W-1 -: 2]);
    // [RULE8] [RULE19] locked or fully protected id page
    wire id_block = idsel_q & (lock_q | (bp_q == BP_FULL));
    // [RULE11] latch and range both required
    wire wr_ok = latch_q & ~reg_hit & ~id_block;

    // [RULE9] both set together keeps both
    wire both_set = sdata_q[BIT_IDSEL] & sdata_q[BIT_LOCK];
    wire idsel_n  = both_set ? idsel_q : sdata_q[BIT_IDSEL];
    wire lock_n   = lock_q | (~both_set & sdata_q[BIT_LOCK]);
    // [RULE21] only bits 7, 4, 3, 2 are non-volatile targets
    wire [3:0] nv_new = {sdata_q[BIT_ARM], lock_n,
                         sdata_q[BIT_BP_HI], sdata_q[BIT_BP_LO]};
    wire [3:0] nv_cur = {arm_q, lock_q, bp_q};
    // [RULE6] [RULE22] status write gate at session end
    wire st_ok = sok_q & latch_q & ~hw_prot;

    // Write session is closed on a byte boundary with data loaded
    wire wr_done = (state_q == S_WDATA) & (bit_q == 5'd0) & nb_q;

    // Session state machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            bit_q   <= 5'd0;
            op_q    <= OP_NONE;
        end else if (~cs_lo) begin
            state_q <= S_IDLE;
            bit_q   <= 5'd0;
        end else if (cs_fall) begin
            state_q <= S_OPC;
            bit_q   <= 5'd0;
            op_q    <= OP_NONE;
        end else if (sck_rise) begin
            bit_q <= bit_q + 5'd1;
            case (state_q)
                S_OPC: begin
                    if (last_byte) begin
                        bit_q <= 5'd0;
                        // [RULE15] busy admits read-status only
                        if (busy_any && byte_in != OP_RD_STATUS) begin
                            state_q <= S_DEAD;
                        end else begin
                            op_q <= byte_in;
                            // [RULE20] six opcodes accepted
                            case (byte_in)
                                OP_RD_STATUS: state_q <= S_OUT;
                                OP_READ:      state_q <= S_ADDR;
                                OP_WRITE:     state_q <= S_ADDR;
                                OP_WR_STATUS: state_q <= S_SDATA;
                                OP_SET_LATCH: state_q <= S_DEAD;
                                OP_CLR_LATCH: state_q <= S_DEAD;
                                default: begin
                                    state_q <= S_DEAD;
                                    op_q    <= OP_NONE;
                                end
                            endcase
                        end
                    end
                end
                S_ADDR: begin
                    if (last_addr) begin
                        bit_q   <= 5'd0;
                        state_q <= (op_q == OP_READ) ? S_OUT : S_WDATA;
                    end
                end
                S_WDATA: begin
                    if (last_byte) begin
                        bit_q <= 5'd0;
                    end
                end
                S_SDATA: begin
                    if (last_byte) begin
                        state_q <= S_DEAD;
                    end
                end
                default: begin
                    bit_q <= 5'd0;
                end
            endcase
        end
    end

    // Input shift, address capture and session flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_q      <= 8'h00;
            addr_q    <= '0;
            ofs_q     <= '0;
            nb_q      <= 1'b0;
            ovr_q     <= 1'b0;
            wp_seen_q <= 1'b0;
            sdata_q   <= 8'h00;
            sok_q     <= 1'b0;
        end else if (cs_fall) begin
            nb_q      <= 1'b0;
            ovr_q     <= 1'b0;
            sok_q     <= 1'b0;
            wp_seen_q <= wp_lo;
        end else begin
            if (cs_lo && wp_lo) begin
                wp_seen_q <= 1'b1;
            end
            if (cs_lo && sck_rise) begin
                sh_q <= byte_in;
                // [RULE13] keep the low 17 of 24 address bits
                if (state_q == S_ADDR) begin
                    addr_q <= {addr_q[ADDR_W-2:0], si_b};
                end
                if (state_q == S_ADDR && last_addr) begin
                    ofs_q <= {addr_q[OFS_W-2:0], si_b};
                end
                // [RULE16] offset wraps inside the page
                if (state_q == S_WDATA && last_byte) begin
                    ofs_q <= ofs_q + 8'h01;
                    nb_q  <= nb_q | wr_ok;
                end
                if (state_q == S_SDATA && last_byte) begin
                    sdata_q <= byte_in;
                    sok_q   <= 1'b1;
                end
            end
            // Full buffer at push time spoils the whole page
            if (push_q && !fifo_in_ready) begin
                ovr_q <= 1'b1;
            end
        end
    end

    // Load word build; refused data never enters the path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_q   <= 1'b0;
            push_w_q <= '0;
        end else begin
            // [RULE4] protected bytes never pushed
            push_q   <= cs_lo & (state_q == S_WDATA) & last_byte & wr_ok;
            push_w_q <= {idsel_q, addr_q[ADDR_W-1:OFS_W], ofs_q, byte_in};
        end
    end

    // Status bits and internal write cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // [RULE10] write disabled after reset
            latch_q   <= STATUS_RESET[BIT_LATCH];
            bp_q      <= STATUS_RESET[BIT_BP_HI:BIT_BP_LO];
            lock_q    <= STATUS_RESET[BIT_LOCK];
            idsel_q   <= STATUS_RESET[BIT_IDSEL];
            arm_q     <= STATUS_RESET[BIT_ARM];
            busy_q    <= STATUS_RESET[BIT_BUSY];
            pend_q    <= 1'b0;
            kind_st_q <= 1'b0;
            nv_pend_q <= 4'h0;
            cnt_q     <= 32'h0;
            commit_q  <= 1'b0;
            abort_q   <= 1'b0;
        end else begin
            commit_q <= 1'b0;
            abort_q  <= 1'b0;
            if (cs_rise) begin
                case (op_q)
                    // [RULE2] [RULE12] latch acts at select rise
                    OP_SET_LATCH: latch_q <= 1'b1;
                    OP_CLR_LATCH: latch_q <= 1'b0;
                    OP_READ: begin
                        // [RULE7] select clears after a read
                        if (state_q == S_OUT) begin
                            idsel_q <= 1'b0;
                        end
                    end
                    OP_WRITE: begin
                        // [RULE14] valid closing edge starts programming
                        if (wr_done && !ovr_q) begin
                            pend_q    <= 1'b1;
                            kind_st_q <= 1'b0;
                        end else if (nb_q) begin
                            abort_q <= 1'b1;
                        end
                    end
                    OP_WR_STATUS: begin
                        if (st_ok) begin
                            idsel_q <= idsel_n;
                            // [RULE24] non-volatile change needs a cycle
                            if (nv_new != nv_cur) begin
                                pend_q    <= 1'b1;
                                kind_st_q <= 1'b1;
                                nv_pend_q <= nv_new;
                            end else begin
                                latch_q <= 1'b0;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            // Programming waits for the load path to drain
            if (pend_q && !busy_q && !fifo_out_valid) begin
                pend_q   <= 1'b0;
                busy_q   <= 1'b1;
                // [RULE25] parameterised cycle length
                cnt_q    <= 32'(WRITE_CYCLES - 1);
                commit_q <= ~kind_st_q;
            end
            if (busy_q) begin
                cnt_q <= cnt_q - 32'h1;
                if (cnt_q == 32'h0) begin
                    busy_q  <= 1'b0;
                    // [RULE17] cycle end disables writes
                    latch_q <= 1'b0;
                    if (kind_st_q) begin
                        {arm_q, lock_q, bp_q} <= nv_pend_q;
                    end else begin
                        // [RULE7] select clears after a write
                        idsel_q <= 1'b0;
                    end
                end
            end
        end
    end

    // Output shifter; first bit leaves on the fall after the command
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_sh_q  <= 8'h00;
            fcnt_q    <= 3'd0;
            so_q      <= 1'b0;
            ld_rd_q   <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            ld_rd_q <= 1'b0;
            if (ld_rd_q) begin
                out_sh_q <= rd_data;
            end
            if (cs_lo && sck_rise && state_q == S_OPC && last_byte) begin
                out_sh_q <= status;
                fcnt_q   <= 3'd0;
            end
            if (cs_lo && state_q == S_ADDR && last_addr) begin
                rd_addr_q <= {addr_q[ADDR_W-2:0], si_b};
                ld_rd_q   <= 1'b1;
                fcnt_q    <= 3'd0;
            end
            if (cs_lo && sck_fall && state_q == S_OUT) begin
                so_q     <= out_sh_q[7];
                out_sh_q <= {out_sh_q[6:0], 1'b0};
                fcnt_q   <= fcnt_q + 3'd1;
                if (fcnt_q == LAST_OUT_BIT) begin
                    if (op_q == OP_RD_STATUS) begin
                        // Status repeats, refreshed every byte
                        out_sh_q <= status;
                    end else begin
                        ld_rd_q <= 1'b1;
                        if (idsel_q) begin
                            rd_addr_q[OFS_W-1:0] <= rd_addr_q[OFS_W-1:0] + 8'h01;
                        end else begin
                            rd_addr_q <= rd_addr_q + 17'h00001;
                        end
                    end
                end
            end
        end
    end

    // Pin and port drive
    assign so          = so_q;
    assign so_oe       = cs_lo & (state_q == S_OUT);
    assign rd_addr     = rd_addr_q;
    assign rd_id       = idsel_q;
    assign prog_commit = commit_q;
    assign prog_abort  = abort_q;

    // Load path buffer toward the array
    load_fifo #(
        .W     (LOAD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_load_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (push_w_q),
        .out_valid (fifo_out_valid),
        .out_ready (ld_ready),
        .out_data  (fifo_out_data)
    );

    assign ld_valid = fifo_out_valid;
    assign {ld_id, ld_addr, ld_data} = fifo_out_data;

endmodule // spi_eeprom_write_protect_control

`default_nettype wire

// file: tb/eeprom_wp_properties.sv
// Checker on the status and write control ports.
// Assumes the bind below onto the block's top module.
`timescale 1ns/1ps
`default_nettype none
module eeprom_wp_properties
    import eeprom_wp_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WC_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Observed ports
    input wire logic       cs_n,
    input wire logic       so_oe,
    input wire logic       prog_commit,
    input wire logic [7:0] status
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Busy length counter; a stuck busy flag overflows the bound
    logic [31:0] busy_q;
    always_ff @(posedge clk) begin
        busy_q <= (sys_rst || !status[BIT_BUSY]) ? 32'h0 : busy_q + 32'h1;
    end
    property p_reset; disable iff (1'b0) sys_rst |=> status == STATUS_RESET; endproperty
    a_reset: assert property (p_reset) else $error("status not clear");
    property p_busy_len; busy_q <= WRITE_CYCLES + 32'd16; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_start; $rose(status[BIT_BUSY]) |-> cs_n; endproperty
    a_start: assert property (p_start) else $error("busy while selected");
    property p_commit; prog_commit |-> status[BIT_BUSY] && status[BIT_LATCH]; endproperty
    a_commit: assert property (p_commit) else $error("commit unqualified");
    property p_end; $fell(status[BIT_BUSY]) |-> !status[BIT_LATCH]; endproperty
    a_end: assert property (p_end) else $error("latch kept");
    property p_bit5; status[5] == 1'b0; endproperty
    a_bit5: assert property (p_bit5) else $error("bit 5 set");
    property p_lock; !$fell(status[BIT_LOCK]); endproperty
    a_lock: assert property (p_lock) else $error("lock cleared");
    property p_pair; !($rose(status[BIT_IDSEL]) && $rose(status[BIT_LOCK])); endproperty
    a_pair: assert property (p_pair) else $error("select and lock set");
    property p_idle; cs_n [*4] |-> !so_oe; endproperty
    a_idle: assert property (p_idle) else $error("output driven idle");
    c_commit: cover property (prog_commit);
    c_latch: cover property ($rose(status[BIT_LATCH]));
    c_done: cover property ($fell(status[BIT_BUSY]));
endmodule // eeprom_wp_properties
bind spi_eeprom_write_protect_control eeprom_wp_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .so_oe(so_oe), .prog_commit(prog_commit), .status(status));
`default_nettype wire

// file: tb/spi_host.sv
// Serial host model, mode 0, one bit per 160 ns.
// Assumes the bench clock; pins change only after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    // Idle: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // Half a link period is 8 clocks
    task automatic half;
        repeat (8) @(posedge clk);
    endtask
    // bit set while clock low, sampled at rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            half();
            sck <= 1'b1;
            rx = {rx[6:0], so};
            half();
            sck <= 1'b0;
        end
    endtask
    // session always closed by select rise
    task automatic send(input logic [7:0] op, input int nb, input logic [31:0] pl, output logic [7:0] rx);
        cs_n <= 1'b0;
        half();
        xfer(op, rx);
        for (int k = 0; k < nb; k++) begin
            xfer(pl[31-8*k -: 8], rx);
        end
        half();
        cs_n <= 1'b1;
        si   <= ~si; // Released line must not keep its last bit
        half();
    endtask
endmodule // spi_host
`default_nettype wire

// file: tb/tb_spi_eeprom_write_protect_control.sv
// Bench for the status and write control block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_spi_eeprom_write_protect_control import eeprom_wp_pkg::*;;
    logic              clk, sys_rst, cs_n, sck, si, wp_n, so, ld_valid;
    logic [ADDR_W-1:0] ld_addr, la;
    logic [7:0]        ld_data, ld, st, rx;
    int                num_errors = 0, n_checks = 0, ld_cnt = 0;
    spi_eeprom_write_protect_control #(.WRITE_CYCLES(600)) dut (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
        .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(), .rd_addr(), .rd_id(), .rd_data(8'h3c),
        .ld_valid(ld_valid), .ld_ready(1'b1), .ld_addr(ld_addr), .ld_id(), .ld_data(ld_data),
        .prog_commit(), .prog_abort(), .status(st));
    spi_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Array always ready: every valid word is taken
    always @(posedge clk) begin
        if (ld_valid === 1'b1) begin
            ld_cnt++;
            la = ld_addr;
            ld = ld_data;
        end
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait for the write cycle to end
    task automatic idle;
        for (int i = 0; i < 800 && st[BIT_BUSY] !== 1'b0; i++) begin
            @(posedge clk);
        end
        if (st[BIT_BUSY] !== 1'b0) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic t_latch;
        `CHK(st, STATUS_RESET)
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        `CHK(st[BIT_LATCH], 1'b1)
        host.send(8'hff, 0, 32'h0, rx);
        host.send(OP_RD_STATUS, 1, 32'h0, rx);
        `CHK(rx, 8'h02)
        host.send(OP_READ, 4, 32'h0000_0000, rx);
        `CHK(rx, 8'h3c)
        host.send(OP_CLR_LATCH, 0, 32'h0, rx);
        `CHK(st[BIT_LATCH], 1'b0)
        host.send(OP_WRITE, 4, 32'h0000_105a, rx);
        `CHK(ld_cnt, 0)
        $display("t_latch done");
    endtask
    task automatic t_write;
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        host.send(OP_WRITE, 4, 32'hfe01_23a5, rx);
        `CHK(ld_cnt, 1)
        `CHK(la, 17'h00123)
        `CHK(ld, 8'ha5)
        `CHK(st[BIT_BUSY], 1'b1)
        host.send(OP_CLR_LATCH, 0, 32'h0, rx);
        host.send(OP_RD_STATUS, 1, 32'h0, rx);
        `CHK(rx[1:0], 2'b11)
        idle();
        `CHK(st[1:0], 2'b00)
        $display("t_write done");
    endtask
    task automatic t_prot;
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        host.send(OP_WR_STATUS, 1, 32'h8c00_0000, rx);
        idle();
        `CHK(st, 8'h8c)
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        host.send(OP_WRITE, 4, 32'h0000_0011, rx);
        `CHK(ld_cnt, 1)
        wp_n <= 1'b0;
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        host.send(OP_WR_STATUS, 1, 32'h8000_0000, rx);
        `CHK(st, 8'h8e)
        wp_n <= 1'b1;
        host.send(OP_SET_LATCH, 0, 32'h0, rx);
        host.send(OP_WR_STATUS, 1, 32'hdc00_0000, rx);
        `CHK(st, 8'h8c)
        $display("t_prot done");
    endtask
    // Reset for 2 cycles, then the scenarios
    initial begin
        sys_rst = 1'b1;
        wp_n    = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_latch();
        t_write();
        t_prot();
        end_sim();
    end
endmodule // tb_spi_eeprom_write_protect_control
`default_nettype wire
